// *** src/usb_fifo_evt_map.svh ***
`ifndef USB_FIFO_EVT_MAP_SVH
`define USB_FIFO_EVT_MAP_SVH

// register byte addresses
`define EVT_STATUS_CTRL_ADDR    32'h90103000
`define EVT_STATUS_EP1_4_ADDR   32'h90103010
`define EVT_STATUS_EP5_8_ADDR   32'h90103020

// flag positions inside one eight-bit slot
`define SLOT_OK_BIT             3'h7
`define SLOT_REFUSED_BIT        3'h6
`define SLOT_FAULT_BIT          3'h5
`define SLOT_WIDTH              8

// slot numbers inside a register
`define SLOT_LOW                2'h0
`define SLOT_MID_LOW            2'h1
`define SLOT_MID_HIGH           2'h2
`define SLOT_HIGH               2'h3

// implemented flag bits per register
`define CTRL_VALID_MASK         32'h0000e0e0
`define EP_VALID_MASK           32'he0e0e0e0

// reset values
`define EVT_STATUS_RESET        32'h00000000
`define RDATA_RESET             32'h00000000

// bus responses
`define RESP_OKAY               2'h0
`define RESP_DECERR             2'h3

`endif

// *** src/usb_fifo_evt_pkg.sv ***
package usb_fifo_evt_pkg;

    // write channel progress, gray coded along idle -> resp -> idle
    typedef enum logic [1:0] {
        WR_IDLE      = 2'h0,
        WR_RESP      = 2'h1,
        WR_HAVE_ADDR = 2'h2,
        WR_HAVE_DATA = 2'h3
    } wr_state_e;

    typedef logic [31:0] word_t;
    typedef logic [1:0]  resp_t;
    typedef logic [2:0]  triplet_t;

endpackage

// *** src/event_flag_bank.sv ***
`timescale 1ns/1ps
`include "usb_fifo_evt_map.svh"

module event_flag_bank
    import usb_fifo_evt_pkg::*;
#(
    parameter word_t VALID_MASK = `EP_VALID_MASK
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // hardware events
    input  wire word_t       set_evt,
    // software write
    input  wire logic        wr_en,
    input  wire word_t       wr_data,
    input  wire logic [3:0]  wr_strb,
    // flag state
    output word_t            flags
);

    word_t wr_ones;
    word_t next_flags;

    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wr_ones[b*`SLOT_WIDTH +: `SLOT_WIDTH] =
                (wr_en && wr_strb[b]) ? wr_data[b*`SLOT_WIDTH +: `SLOT_WIDTH] : 8'h00;
        end
    end

    // one written to a set flag clears it, to a clear flag sets it
    // a hardware event wins over a clearing write in the same cycle
    assign next_flags = ((flags ^ wr_ones) | set_evt) & VALID_MASK;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flags <= `EVT_STATUS_RESET;
        end else begin
            flags <= next_flags;
        end
    end

endmodule // event_flag_bank

// *** src/usb_dev_fifo_irq_status.sv ***
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
`include "usb_fifo_evt_map.svh"

module usb_dev_fifo_irq_status
    import usb_fifo_evt_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // write address channel
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    // write data channel
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // write response channel
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // read address channel
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    // read data channel
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // control endpoint out events
    input  wire logic        fifo1_handshake_ok,
    input  wire logic        fifo1_refused,
    input  wire logic        fifo1_fault,
    // control endpoint in events
    input  wire logic        fifo2_handshake_ok,
    input  wire logic        fifo2_refused,
    input  wire logic        fifo2_fault,
    // endpoint 1 events
    input  wire logic        fifo3_handshake_ok,
    input  wire logic        fifo3_refused,
    input  wire logic        fifo3_fault,
    // endpoint 2 events
    input  wire logic        fifo4_handshake_ok,
    input  wire logic        fifo4_refused,
    input  wire logic        fifo4_fault,
    // endpoint 3 events
    input  wire logic        fifo5_handshake_ok,
    input  wire logic        fifo5_refused,
    input  wire logic        fifo5_fault,
    // endpoint 4 events
    input  wire logic        fifo6_handshake_ok,
    input  wire logic        fifo6_refused,
    input  wire logic        fifo6_fault,
    // endpoint 5 events
    input  wire logic        fifo7_handshake_ok,
    input  wire logic        fifo7_refused,
    input  wire logic        fifo7_fault,
    // endpoint 6 events
    input  wire logic        fifo8_handshake_ok,
    input  wire logic        fifo8_refused,
    input  wire logic        fifo8_fault,
    // endpoint 7 events
    input  wire logic        fifo9_handshake_ok,
    input  wire logic        fifo9_refused,
    input  wire logic        fifo9_fault,
    // endpoint 8 events
    input  wire logic        fifo10_handshake_ok,
    input  wire logic        fifo10_refused,
    input  wire logic        fifo10_fault
);

    // places an ok, refused, fault triplet into its slot of a register
    function automatic word_t place_triplet(input triplet_t evt, input logic [1:0] slot);
        word_t w;
        w = '0;
        w[{slot, `SLOT_OK_BIT}]      = evt[2];
        w[{slot, `SLOT_REFUSED_BIT}] = evt[1];
        w[{slot, `SLOT_FAULT_BIT}]   = evt[0];
        return w;
    endfunction

    // register decode, one hot over the three status words
    function automatic logic [2:0] decode_addr(input logic [31:0] addr);
        logic [2:0] sel;
        sel    = 3'h0;
        sel[0] = (addr == `EVT_STATUS_CTRL_ADDR);
        sel[1] = (addr == `EVT_STATUS_EP1_4_ADDR);
        sel[2] = (addr == `EVT_STATUS_EP5_8_ADDR);
        return sel;
    endfunction

    word_t      set_ctrl;
    word_t      set_ep1_4;
    word_t      set_ep5_8;
    word_t      fifo_event_status_ctrl_ep;
    word_t      fifo_event_status_ep1_ep4;
    word_t      fifo_event_status_ep5_ep8;

    wr_state_e  wr_state;
    wr_state_e  next_wr_state;
    logic       aw_hs;
    logic       w_hs;
    logic       wr_fire;
    logic [31:0] aw_addr_q;
    word_t      w_data_q;
    logic [3:0] w_strb_q;
    logic [31:0] wr_addr;
    word_t      wr_data;
    logic [3:0] wr_strb;
    logic [2:0] wr_sel;
    logic [2:0] rd_sel;
    logic       ar_hs;

    // event vectors, one triplet per fifo
    always_comb begin
        set_ctrl = place_triplet({fifo2_handshake_ok, fifo2_refused, fifo2_fault},
                                 `SLOT_MID_LOW)
                 | place_triplet({fifo1_handshake_ok, fifo1_refused, fifo1_fault},
                                 `SLOT_LOW);
        set_ep1_4 = place_triplet({fifo6_handshake_ok, fifo6_refused, fifo6_fault},
                                  `SLOT_HIGH)
                  | place_triplet({fifo5_handshake_ok, fifo5_refused, fifo5_fault},
                                  `SLOT_MID_HIGH)
                  | place_triplet({fifo4_handshake_ok, fifo4_refused, fifo4_fault},
                                  `SLOT_MID_LOW)
                  | place_triplet({fifo3_handshake_ok, fifo3_refused, fifo3_fault},
                                  `SLOT_LOW);
        set_ep5_8 = place_triplet({fifo10_handshake_ok, fifo10_refused, fifo10_fault},
                                  `SLOT_HIGH)
                  | place_triplet({fifo9_handshake_ok, fifo9_refused, fifo9_fault},
                                  `SLOT_MID_HIGH)
                  | place_triplet({fifo8_handshake_ok, fifo8_refused, fifo8_fault},
                                  `SLOT_MID_LOW)
                  | place_triplet({fifo7_handshake_ok, fifo7_refused, fifo7_fault},
                                  `SLOT_LOW);
    end

    // write channel handshakes
    assign s_axi_awready = (wr_state == WR_IDLE) || (wr_state == WR_HAVE_DATA);
    assign s_axi_wready  = (wr_state == WR_IDLE) || (wr_state == WR_HAVE_ADDR);
    assign s_axi_bvalid  = (wr_state == WR_RESP);
    assign aw_hs         = s_axi_awvalid && s_axi_awready;
    assign w_hs          = s_axi_wvalid && s_axi_wready;

    // write completes once both address and data are in hand
    assign wr_fire = (aw_hs || (wr_state == WR_HAVE_ADDR))
                  && (w_hs || (wr_state == WR_HAVE_DATA));
    assign wr_addr = aw_hs ? s_axi_awaddr : aw_addr_q;
    assign wr_data = w_hs ? s_axi_wdata : w_data_q;
    assign wr_strb = w_hs ? s_axi_wstrb : w_strb_q;
    assign wr_sel  = wr_fire ? decode_addr(wr_addr) : 3'h0;

    always_comb begin
        next_wr_state = wr_state;
        case (wr_state)
            WR_IDLE: begin
                if (wr_fire) begin
                    next_wr_state = WR_RESP;
                end else if (aw_hs) begin
                    next_wr_state = WR_HAVE_ADDR;
                end else if (w_hs) begin
                    next_wr_state = WR_HAVE_DATA;
                end
            end
            WR_HAVE_ADDR: begin
                if (w_hs) begin
                    next_wr_state = WR_RESP;
                end
            end
            WR_HAVE_DATA: begin
                if (aw_hs) begin
                    next_wr_state = WR_RESP;
                end
            end
            WR_RESP: begin
                if (s_axi_bready) begin
                    next_wr_state = WR_IDLE;
                end
            end
            default: begin
                next_wr_state = WR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_state <= WR_IDLE;
        end else begin
            wr_state <= next_wr_state;
        end
    end

    // held write address and data
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            aw_addr_q <= `EVT_STATUS_RESET;
            w_data_q  <= `EVT_STATUS_RESET;
            w_strb_q  <= 4'h0;
        end else begin
            if (aw_hs) begin
                aw_addr_q <= s_axi_awaddr;
            end
            if (w_hs) begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
        end
    end

    // write response, unmapped addresses answer decode error
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_bresp <= `RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bresp <= (decode_addr(wr_addr) != 3'h0) ? `RESP_OKAY : `RESP_DECERR;
        end
    end

    // flag banks; masks keep unused and reserved bits at zero
    event_flag_bank #(
        .VALID_MASK (`CTRL_VALID_MASK)
    ) u_bank_ctrl (
        .clk     (clk),
        .sys_rst (sys_rst),
        .set_evt (set_ctrl),
        .wr_en   (wr_sel[0]),
        .wr_data (wr_data),
        .wr_strb (wr_strb),
        .flags   (fifo_event_status_ctrl_ep)
    );

    event_flag_bank #(
        .VALID_MASK (`EP_VALID_MASK)
    ) u_bank_ep1_4 (
        .clk     (clk),
        .sys_rst (sys_rst),
        .set_evt (set_ep1_4),
        .wr_en   (wr_sel[1]),
        .wr_data (wr_data),
        .wr_strb (wr_strb),
        .flags   (fifo_event_status_ep1_ep4)
    );

    event_flag_bank #(
        .VALID_MASK (`EP_VALID_MASK)
    ) u_bank_ep5_8 (
        .clk     (clk),
        .sys_rst (sys_rst),
        .set_evt (set_ep5_8),
        .wr_en   (wr_sel[2]),
        .wr_data (wr_data),
        .wr_strb (wr_strb),
        .flags   (fifo_event_status_ep5_ep8)
    );

    // read channel: one read at a time, data from flops
    assign s_axi_arready = !s_axi_rvalid;
    assign ar_hs         = s_axi_arvalid && s_axi_arready;
    assign rd_sel        = decode_addr(s_axi_araddr);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_rvalid <= 1'b0;
        end else if (ar_hs) begin
            s_axi_rvalid <= 1'b1;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_rdata <= `RDATA_RESET;
            s_axi_rresp <= `RESP_OKAY;
        end else if (ar_hs) begin
            s_axi_rresp <= (rd_sel != 3'h0) ? `RESP_OKAY : `RESP_DECERR;
            s_axi_rdata <= ({32{rd_sel[0]}} & fifo_event_status_ctrl_ep)
                         | ({32{rd_sel[1]}} & fifo_event_status_ep1_ep4)
                         | ({32{rd_sel[2]}} & fifo_event_status_ep5_ep8);
        end
    end

endmodule // usb_dev_fifo_irq_status

// *** verif/usb_core_model.sv ***
`timescale 1ns/1ps

// stands in for the core: three outcome lines per fifo, ok/refused/fault
module usb_core_model (
    // clock
    input  wire logic        clk,
    // request from the bench
    input  wire logic        go,
    input  wire logic        hold,
    input  wire logic [4:0]  sel,
    // outcome lines, fifo f kind k at bit f*3+k (k: fault, refused, ok)
    output logic      [29:0] ev
);
    always_ff @(posedge clk) begin
        if (go) begin
            ev <= 30'h1 << sel;
        end else if (!hold) begin
            ev <= '0;
        end
    end
endmodule // usb_core_model

// *** verif/usb_fifo_status_chk.sv ***
`timescale 1ns/1ps
`include "usb_fifo_evt_map.svh"

module usb_fifo_status_chk (
    // clock and reset
    input wire logic        clk,
    input wire logic        sys_rst,
    // register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic        s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    // watched events
    input wire logic        fifo1_handshake_ok,
    input wire logic        fifo2_fault
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [31:0] ra;
    logic        hit, wt, rt, ctl;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ra <= '0;
        end else if (rt) begin
            ra <= s_axi_araddr;
        end
    end
    assign wt = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    assign rt = s_axi_arvalid && s_axi_arready;
    assign ctl = rt && !wt && s_axi_araddr == `EVT_STATUS_CTRL_ADDR;
    assign hit = ra == `EVT_STATUS_CTRL_ADDR || ra == `EVT_STATUS_EP1_4_ADDR
               || ra == `EVT_STATUS_EP5_8_ADDR;
    a_write_answer:
        assert property (wt |=> s_axi_bvalid) else $error("write not answered");
    a_read_answer:
        assert property (rt |=> s_axi_rvalid) else $error("read not answered");
    a_write_busy:
        assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answering");
    a_read_busy:
        assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
    a_upper_zero:
        assert property (s_axi_rvalid && ra == `EVT_STATUS_CTRL_ADDR |-> s_axi_rdata[31:16] == 16'h0)
        else $error("upper half not zero");
    a_gap_zero:
        assert property (s_axi_rvalid |-> (s_axi_rdata & ~`EP_VALID_MASK) == 32'h0)
        else $error("reserved bits set");
    a_unmapped_err:
        assert property (s_axi_rvalid && !hit |-> s_axi_rresp == 2'h3 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_mapped_ok:
        assert property (s_axi_rvalid && hit |-> s_axi_rresp == 2'h0) else $error("bad resp");
    a_fault_seen:
        assert property ($past(fifo2_fault && !sys_rst) && ctl |=> s_axi_rdata[13])
        else $error("fault not latched");
    a_ok_seen:
        assert property ($past(fifo1_handshake_ok && !sys_rst) && ctl |=> s_axi_rdata[7])
        else $error("ok not latched");
endmodule // usb_fifo_status_chk

bind usb_dev_fifo_irq_status usb_fifo_status_chk u_chk (
    .clk(clk), .sys_rst(sys_rst),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .fifo1_handshake_ok(fifo1_handshake_ok), .fifo2_fault(fifo2_fault)
);

// *** verif/usb_dev_fifo_irq_status_tb.sv ***
`timescale 1ns/1ps
`include "usb_fifo_evt_map.svh"

module usb_dev_fifo_irq_status_tb
    import usb_fifo_evt_pkg::*;
;
    logic        clk, sys_rst, go, hold, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [4:0]  sel;
    logic [29:0] ev;
    word_t       s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, lfsr, rd;
    logic [3:0]  s_axi_wstrb;
    logic [2:0]  s_axi_awprot, s_axi_arprot;
    resp_t       s_axi_bresp, s_axi_rresp, rs;
    word_t       m [3];
    int          miscompares, n_compared, cyc;

    usb_core_model u_core (.clk(clk), .go(go), .hold(hold), .sel(sel), .ev(ev));
    usb_dev_fifo_irq_status DUT (
        .clk(clk), .sys_rst(sys_rst),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .fifo1_handshake_ok(ev[2]), .fifo1_refused(ev[1]), .fifo1_fault(ev[0]),
        .fifo2_handshake_ok(ev[5]), .fifo2_refused(ev[4]), .fifo2_fault(ev[3]),
        .fifo3_handshake_ok(ev[8]), .fifo3_refused(ev[7]), .fifo3_fault(ev[6]),
        .fifo4_handshake_ok(ev[11]), .fifo4_refused(ev[10]), .fifo4_fault(ev[9]),
        .fifo5_handshake_ok(ev[14]), .fifo5_refused(ev[13]), .fifo5_fault(ev[12]),
        .fifo6_handshake_ok(ev[17]), .fifo6_refused(ev[16]), .fifo6_fault(ev[15]),
        .fifo7_handshake_ok(ev[20]), .fifo7_refused(ev[19]), .fifo7_fault(ev[18]),
        .fifo8_handshake_ok(ev[23]), .fifo8_refused(ev[22]), .fifo8_fault(ev[21]),
        .fifo9_handshake_ok(ev[26]), .fifo9_refused(ev[25]), .fifo9_fault(ev[24]),
        .fifo10_handshake_ok(ev[29]), .fifo10_refused(ev[28]), .fifo10_fault(ev[27])
    );

    always #25 clk = ~clk;

    function automatic word_t nxt(word_t v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic word_t addr(int r);
        return r == 0 ? `EVT_STATUS_CTRL_ADDR : r == 1 ? `EVT_STATUS_EP1_4_ADDR
                      : `EVT_STATUS_EP5_8_ADDR;
    endfunction
    function automatic int rg(int s);
        return s < 6 ? 0 : (s / 3 - 2) / 4 + 1;
    endfunction
    function automatic int bp(int s);
        return (s < 6 ? s / 3 : (s / 3 - 2) % 4) * 8 + 5 + s % 3;
    endfunction

    task automatic end_of_test();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic cmp_word(word_t got, word_t exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp_resp(resp_t got, resp_t exp);
        cmp_word({30'h0, got}, {30'h0, exp});
    endtask

    // bus write; both channels offered together, bready held high
    task automatic wr(word_t a, word_t d, logic [3:0] st, resp_t er);
        logic b, ta, tw;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(negedge clk);
            b = s_axi_bvalid;
            rs = s_axi_bresp;
            ta = s_axi_awready;
            tw = s_axi_wready;
            @(posedge clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end while (!b);
        cmp_resp(rs, er);
    endtask
    task automatic rd_chk(word_t a, word_t ed, resp_t er);
        logic v, t;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(negedge clk);
            v = s_axi_rvalid;
            t = s_axi_arready;
            rd = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge clk);
            if (t) s_axi_arvalid <= 1'b0;
        end while (!v);
        cmp_word(rd, ed);
        cmp_resp(rs, er);
    endtask
    // one outcome from the core, latched by the edge before return
    task automatic pulse(int s, logic h);
        sel <= 5'(s);
        go <= 1'b1;
        hold <= h;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        m[rg(s)][bp(s)] = 1'b1;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            miscompares++;
            end_of_test();
        end
    end

    initial begin
        clk = 1'b0;
        sys_rst = 1'b1;
        go = 1'b0;
        hold = 1'b0;
        sel = '0;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_bready = 1'b1;
        s_axi_rready = 1'b1;
        s_axi_awprot = '0;
        s_axi_arprot = '0;
        s_axi_awaddr = '0;
        s_axi_wdata = '0;
        s_axi_wstrb = '0;
        s_axi_araddr = '0;
        foreach (m[i]) m[i] = '0;
        lfsr = 32'd92207;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        for (int r = 0; r < 3; r++) rd_chk(addr(r), 32'h0, `RESP_OKAY);
        wr(32'h90103004, 32'hffffffff, 4'hf, `RESP_DECERR);
        rd_chk(32'h90103004, 32'h0, `RESP_DECERR);
        $display("test reset done");
        for (int s = 0; s < 30; s++) begin
            pulse(s, 1'b0);
            rd_chk(addr(rg(s)), m[rg(s)], `RESP_OKAY);
            wr(addr(rg(s)), 32'h0, 4'hf, `RESP_OKAY);
            rd_chk(addr(rg(s)), m[rg(s)], `RESP_OKAY);
            wr(addr(rg(s)), 32'h1 << bp(s), 4'hf, `RESP_OKAY);
            m[rg(s)][bp(s)] = 1'b0;
            rd_chk(addr(rg(s)), m[rg(s)], `RESP_OKAY);
        end
        $display("test flag map done");
        for (int i = 0; i < 40; i++) begin
            int r;
            logic [3:0] st;
            lfsr = nxt(lfsr);
            if (lfsr[12]) pulse(lfsr[4:0] % 30, 1'b0);
            r = lfsr[9:8] % 3;
            st = lfsr[23:20] | 4'h1;
            lfsr = nxt(lfsr);
            wr(addr(r), lfsr, st, `RESP_OKAY);
            m[r] ^= lfsr & (r == 0 ? `CTRL_VALID_MASK : `EP_VALID_MASK)
                    & {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
            rd_chk(addr(r), m[r], `RESP_OKAY);
        end
        $display("test random writes done");
        pulse(7, 1'b1);
        wr(addr(1), 32'h1 << bp(7), 4'hf, `RESP_OKAY);
        rd_chk(addr(1), m[1], `RESP_OKAY);
        hold <= 1'b0;
        repeat (2) @(posedge clk);
        wr(addr(1), 32'h1 << bp(7), 4'hf, `RESP_OKAY);
        m[1][bp(7)] = 1'b0;
        rd_chk(addr(1), m[1], `RESP_OKAY);
        $display("test held event done");
        end_of_test();
    end
endmodule // usb_dev_fifo_irq_status_tb
